// *** inc/rre_pkg.sv ***
/*
 * constants for the return and rotate execute block: opcode patterns,
 * instruction field positions, stack depth and reset values.
 * assumes 14-bit instruction words and an 8-bit datapath.
 */
package rre_pkg;
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int STACK_DEPTH = 8;
    localparam int FILE_ADDR_W = 7;

    // opcode matching: (word & mask) == pattern
    localparam logic [13:0] RET_MASK = 14'h3fff;
    localparam logic [13:0] RET_PATTERN = 14'h0008;
    localparam logic [13:0] LITRET_MASK = 14'h3c00;
    localparam logic [13:0] LITRET_PATTERN = 14'h3400;
    localparam logic [13:0] SHRC_MASK = 14'h3f00;
    localparam logic [13:0] SHRC_PATTERN = 14'h0c00;

    // instruction fields
    localparam int LIT_LSB = 0;
    localparam int FILE_LSB = 0;
    localparam int DEST_BIT = 7;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // cycle counts
    localparam int BRANCH_CYCLES = 2;
    localparam int SHRC_CYCLES = 1;

    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [12:0] PC_RST = 13'h0000;

    typedef enum logic {
        RRE_EXEC = 1'b0,
        RRE_FLUSH = 1'b1
    } rre_phase_t;
endpackage

// *** rtl/rre_exec.sv ***
/*
 * decode and execute of subroutine return, literal return and
 * rotate-right-through-carry for an 8-bit core with 14-bit words.
 * assumes the core gives one cycleEn pulse per instruction cycle with
 * the current word, the addressed file register value and the carry
 * flag all valid in that cycle; results appear one clock later.
 */
// How it works
// - literal return writes the 8-bit immediate into the accumulator
// - literal return pops the stack and loads the program counter from it
// - literal return takes two cycles; the prefetched word is discarded
// - subroutine return pops the stack into program counter, nothing else changes
// - subroutine return takes two instruction cycles
// - rotate right: old carry into bit 7, old bit 0 into carry
// - destination bit 0 sends the result to the accumulator only
// - destination bit 1 writes the result back to the file register
// - rotate decodes a 7-bit register address and one destination bit
`timescale 1ns/100ps
module rre_exec #(
    parameter int PC_W = rre_pkg::PC_W
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic cycleEn,
    input wire logic [13:0] instrWord,
    input wire logic [7:0] fileRdData,
    input wire logic carryIn,
    input wire logic pushEn,
    input wire logic [PC_W-1:0] pushAddr,
    output logic accWrEn,
    output logic [7:0] accWrData,
    output logic fileWrEn,
    output logic [6:0] fileWrAddr,
    output logic [7:0] fileWrData,
    output logic carryWrEn,
    output logic carryWrData,
    output logic pcLoadEn,
    output logic [PC_W-1:0] pcLoadAddr,
    output logic fetchFlush,
    output logic busy
);
    typedef struct packed {
        rre_pkg::rre_phase_t phase;
        logic accWrEn;
        logic [7:0] accWrData;
        logic fileWrEn;
        logic [6:0] fileWrAddr;
        logic [7:0] fileWrData;
        logic carryWrEn;
        logic carryWrData;
        logic pcLoadEn;
        logic [PC_W-1:0] pcLoadAddr;
        logic fetchFlush;
        logic busy;
    } rre_exec_state_t;

    rre_exec_state_t s_q;
    rre_exec_state_t s_d;
    logic [PC_W-1:0] stackTop;
    logic popEn;
    logic isRet;
    logic isLitRet;
    logic isShift;
    logic [7:0] rotated;

    function automatic logic opMatch(input logic [13:0] w, input logic [13:0] mask,
                                     input logic [13:0] pattern);
        opMatch = (w & mask) == pattern;
    endfunction

    always_comb begin
        isRet = opMatch(instrWord, rre_pkg::RET_MASK, rre_pkg::RET_PATTERN);
        isLitRet = opMatch(instrWord, rre_pkg::LITRET_MASK, rre_pkg::LITRET_PATTERN);
        isShift = opMatch(instrWord, rre_pkg::SHRC_MASK, rre_pkg::SHRC_PATTERN);
    end

    // rotation through carry
    assign rotated = {carryIn, fileRdData[7:1]};

    // pops only on a decoded return in an execute cycle
    assign popEn = cycleEn && (s_q.phase == rre_pkg::RRE_EXEC)
                   && (isRet || isLitRet) && !pushEn;

    rre_stack #(
        .DEPTH(rre_pkg::STACK_DEPTH),
        .AW(PC_W)
    ) u_stack (
        .clock(clock),
        .nrst(nrst),
        .pushEn(pushEn),
        .pushAddr(pushAddr),
        .popEn(popEn),
        .stackTop(stackTop)
    );

    always_comb begin
        s_d = s_q;
        s_d.accWrEn = 1'b0;
        s_d.fileWrEn = 1'b0;
        s_d.carryWrEn = 1'b0;
        s_d.pcLoadEn = 1'b0;
        s_d.fetchFlush = 1'b0;
        if (cycleEn) begin
            unique case (s_q.phase)
                rre_pkg::RRE_EXEC: begin
                    if (isLitRet) begin
                        s_d.accWrEn = 1'b1;
                        s_d.accWrData = instrWord[rre_pkg::LIT_LSB +: 8];
                        s_d.pcLoadEn = 1'b1;
                        s_d.pcLoadAddr = stackTop;
                        s_d.phase = rre_pkg::RRE_FLUSH;
                        s_d.busy = 1'b1;
                    end else if (isRet) begin
                        s_d.pcLoadEn = 1'b1;
                        s_d.pcLoadAddr = stackTop;
                        s_d.phase = rre_pkg::RRE_FLUSH;
                        s_d.busy = 1'b1;
                    end else if (isShift) begin
                        // single cycle, carry is the only flag touched
                        s_d.carryWrEn = 1'b1;
                        s_d.carryWrData = fileRdData[0];
                        s_d.fileWrAddr = instrWord[rre_pkg::FILE_LSB +: 7];
                        if (instrWord[rre_pkg::DEST_BIT] == rre_pkg::DEST_ACC) begin
                            s_d.accWrEn = 1'b1;
                            s_d.accWrData = rotated;
                        end else begin
                            s_d.fileWrEn = 1'b1;
                            s_d.fileWrData = rotated;
                        end
                    end
                end
                rre_pkg::RRE_FLUSH: begin
                    // second cycle: the prefetched word is thrown away
                    s_d.fetchFlush = 1'b1;
                    s_d.busy = 1'b0;
                    s_d.phase = rre_pkg::RRE_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            s_q <= '{phase: rre_pkg::RRE_EXEC, accWrData: rre_pkg::DATA_RST,
                     fileWrData: rre_pkg::DATA_RST, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign accWrEn = s_q.accWrEn;
    assign accWrData = s_q.accWrData;
    assign fileWrEn = s_q.fileWrEn;
    assign fileWrAddr = s_q.fileWrAddr;
    assign fileWrData = s_q.fileWrData;
    assign carryWrEn = s_q.carryWrEn;
    assign carryWrData = s_q.carryWrData;
    assign pcLoadEn = s_q.pcLoadEn;
    assign pcLoadAddr = s_q.pcLoadAddr;
    assign fetchFlush = s_q.fetchFlush;
    assign busy = s_q.busy;
endmodule

// *** rtl/rre_stack.sv ***
/*
 * eight-level circular return stack with push and pop.
 * assumes push and pop come from logic on the same clock and are
 * never asserted together.
 */
`timescale 1ns/100ps
module rre_stack #(
    parameter int DEPTH = rre_pkg::STACK_DEPTH,
    parameter int AW = rre_pkg::PC_W
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic pushEn,
    input wire logic [AW-1:0] pushAddr,
    input wire logic popEn,
    output logic [AW-1:0] stackTop
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][AW-1:0] mem;
        logic [PW-1:0] ptr;
    } rre_stack_state_t;

    rre_stack_state_t s_q;
    rre_stack_state_t s_d;

    // ptr names the next free slot; top is the slot below it, wrapping
    assign stackTop = s_q.mem[s_q.ptr - PW'(1)];

    always_comb begin
        s_d = s_q;
        if (pushEn) begin
            s_d.mem[s_q.ptr] = pushAddr;
            s_d.ptr = s_q.ptr + PW'(1);
        end else if (popEn) begin
            s_d.ptr = s_q.ptr - PW'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// *** sim/rre_core_model.sv ***
/* core datapath stand-in; assumes result pulses of rre_exec */
`timescale 1ns/100ps
module rre_core_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [13:0] instrWord,
    input wire logic accWrEn,
    input wire logic [7:0] accWrData,
    input wire logic fileWrEn,
    input wire logic [6:0] fileWrAddr,
    input wire logic [7:0] fileWrData,
    input wire logic carryWrEn,
    input wire logic carryWrData,
    input wire logic pcLoadEn,
    input wire logic [12:0] pcLoadAddr,
    output logic [7:0] fileRdData,
    output logic carryIn
);
    logic [7:0] regs [128];
    logic [7:0] acc;
    logic [12:0] pc;
    assign fileRdData = regs[instrWord[6:0]];
    always @(posedge clock) begin
        if (!nrst)
            carryIn <= 1'b0;
        else if (carryWrEn)
            carryIn <= carryWrData;
        if (accWrEn)
            acc <= accWrData;
        if (fileWrEn)
            regs[fileWrAddr] <= fileWrData;
        if (pcLoadEn)
            pc <= pcLoadAddr;
    end
endmodule

// *** sim/rre_exec_properties.sv ***
/* port assertions for rre_exec; bound to every instance below */
`timescale 1ns/100ps
module rre_exec_properties (
    input wire logic clock,
    input wire logic nrst,
    input wire logic cycleEn,
    input wire logic [13:0] instrWord,
    input wire logic [7:0] fileRdData,
    input wire logic carryIn,
    input wire logic accWrEn,
    input wire logic [7:0] accWrData,
    input wire logic fileWrEn,
    input wire logic [6:0] fileWrAddr,
    input wire logic [7:0] fileWrData,
    input wire logic carryWrEn,
    input wire logic carryWrData,
    input wire logic pcLoadEn,
    input wire logic fetchFlush,
    input wire logic busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    wire logic go = cycleEn && !busy;
    wire logic [7:0] rot = {carryIn, fileRdData[7:1]};
    sequence sLit; go && instrWord[13:10] == 4'hd; endsequence
    sequence sRet; go && instrWord == 14'h0008; endsequence
    sequence sShr; go && instrWord[13:8] == 6'h0c; endsequence
    AST_LIT_ACC: assert property (sLit |=> accWrEn
        && accWrData == $past(instrWord[7:0])) else $error("bad literal");
    AST_LIT_PC: assert property (sLit |=> pcLoadEn && busy)
        else $error("no pc load");
    AST_FLUSH: assert property (pcLoadEn && cycleEn |=> fetchFlush && !busy)
        else $error("no flush");
    AST_RET: assert property (sRet |=> pcLoadEn && busy
        && !accWrEn && !carryWrEn && !fileWrEn) else $error("bad return");
    AST_SHR_C: assert property (sShr |=> carryWrEn
        && carryWrData == $past(fileRdData[0])) else $error("bad carry");
    AST_SHR_W: assert property (sShr ##0 !instrWord[7] |=> accWrEn && !fileWrEn
        && accWrData == $past(rot)) else $error("bad acc rotate");
    AST_SHR_F: assert property (sShr ##0 instrWord[7] |=> fileWrEn && !accWrEn
        && fileWrData == $past(rot) && fileWrAddr == $past(instrWord[6:0]))
        else $error("bad file rotate");
    AST_SHR_1: assert property (sShr |=> !busy && !pcLoadEn)
        else $error("rotate not single");
endmodule
bind rre_exec rre_exec_properties chk_u (.*);

// *** sim/rre_exec_tb.sv ***
/* bench for rre_exec; assumes rre_core_model as the datapath */
`timescale 1ns/100ps
module rre_exec_tb;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic cycleEn = 1'b0;
    logic pushEn = 1'b0;
    logic [13:0] instrWord = 14'h0000;
    logic [12:0] pushAddr = 13'h0000;
    logic [7:0] accWrData, fileWrData, fileRdData;
    logic [6:0] fileWrAddr;
    logic [12:0] pcLoadAddr;
    logic accWrEn, fileWrEn, carryWrEn, carryWrData, pcLoadEn, carryIn, fetchFlush, busy;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;
    always #2 clock = ~clock;
    rre_exec dut_u (.*);
    rre_core_model pm_u (.*);
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [13:0] w, input int n);
        instrWord <= w;
        cycleEn <= 1'b1;
        repeat (n) @(posedge clock);
        cycleEn <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic push(input logic [12:0] a);
        pushAddr <= a;
        pushEn <= 1'b1;
        @(posedge clock);
        pushEn <= 1'b0;
        @(posedge clock);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic t_rotate;
        pm_u.regs[5] = 8'he6;
        pm_u.regs[127] = 8'h01;
        run(14'h0c05, 1);
        chk(pm_u.acc, 8'h73);
        chk(pm_u.regs[5], 8'he6);
        run(14'h0c85, 1);
        chk(pm_u.regs[5], 8'h73);
        run(14'h0cff, 1);
        chk(pm_u.regs[127], 8'h00);
        chk(pm_u.carryIn, 1'b1);
        run(14'h0c7f, 1);
        chk(pm_u.acc, 8'h80);
        $display("rotate done");
    endtask
    task automatic t_returns;
        push(13'h0123);
        push(13'h1abc);
        run(14'h375a, 2);
        chk(pm_u.acc, 8'h5a);
        chk(pm_u.pc, 13'h1abc);
        run(14'h0008, 2);
        chk(pm_u.pc, 13'h0123);
        chk(pm_u.acc, 8'h5a);
        $display("returns done");
    endtask
    task automatic t_stack;
        for (int i = 1; i <= 9; i++)
            push(13'(i));
        for (int i = 9; i >= 2; i--) begin
            run(14'h3400, 2);
            chk(pm_u.pc, 13'(i));
        end
        run(14'h0008, 2);
        chk(pm_u.pc, 13'h0009);
        $display("stack done");
    endtask
    task automatic t_flush;
        push(13'h0055);
        instrWord <= 14'h0008;
        cycleEn <= 1'b1;
        @(posedge clock);
        #1;
        chk(busy, 1'b1);
        chk(fetchFlush, 1'b0);
        @(posedge clock);
        cycleEn <= 1'b0;
        #1;
        chk(fetchFlush, 1'b1);
        chk(busy, 1'b0);
        @(posedge clock);
        chk(pm_u.pc, 13'h0055);
        $display("flush done");
    endtask
    task automatic t_reset;
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        run(14'h0008, 2);
        chk(pm_u.pc, 13'h0000);
        $display("reset done");
    endtask
    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        t_rotate();
        t_returns();
        t_stack();
        t_flush();
        t_reset();
        close_out();
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 500) begin
            fail_count++;
            $display("wrong value at %0t: timeout", $time);
            close_out();
        end
    end
endmodule
